// ==== can_id_filter_pkg.sv ====
package can_id_filter_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int NUM_OBJ = 15;
	localparam int PAGE_W = 4;
	localparam int ID_W = 29;
	localparam int STD_ID_W = 11;

	localparam logic [7:0] ADDR_TAG_BYTE_ONE = 8'hBC;
	localparam logic [7:0] ADDR_TAG_BYTE_TWO = 8'hBD;
	localparam logic [7:0] ADDR_TAG_BYTE_THREE = 8'hBE;
	localparam logic [7:0] ADDR_TAG_BYTE_FOUR = 8'hBF;
	localparam logic [7:0] ADDR_FILTER_BYTE_ONE = 8'hC4;
	localparam logic [7:0] ADDR_FILTER_BYTE_TWO = 8'hC5;
	localparam logic [7:0] ADDR_FILTER_BYTE_THREE = 8'hC6;
	localparam logic [7:0] ADDR_FILTER_BYTE_FOUR = 8'hC7;

	localparam int RTR_POS = 2;
	localparam int RB1_POS = 1;
	localparam int RB0_POS = 0;
	localparam int IDE_POS = 0;
	localparam int STD_SHIFT = 18;

	// One message object's identifier storage; both views map onto it.
	typedef struct packed {
		logic [ID_W-1:0] identifier_tag_bits;
		logic remote_request_tag;
		logic reserved_one_tag;
		logic reserved_zero_tag;
		logic [ID_W-1:0] identifier_mask_bits;
		logic remote_request_filter;
		logic extension_flag_filter;
	} obj_entry_t;

	localparam int ENTRY_W = $bits(obj_entry_t);

endpackage

// ==== can_id_match.sv ====
`timescale 1ns/1ns
module can_id_match (
	input wire logic [can_id_filter_pkg::ENTRY_W-1:0] entry_i,
	input wire logic [can_id_filter_pkg::ID_W-1:0] rx_id_i,
	input wire logic rx_rtr_i,
	input wire logic rx_ide_i,
	input wire logic obj_ide_i,
	output logic hit_o
);
	can_id_filter_pkg::obj_entry_t e;
	logic [can_id_filter_pkg::ID_W-1:0] diff;
	logic rtr_ok;
	logic ide_ok;

	assign e = entry_i;
	// A cleared mask bit forces a match; a set one demands equality.
	assign diff = (rx_id_i ^ e.identifier_tag_bits) & e.identifier_mask_bits;
	assign rtr_ok = !e.remote_request_filter || (rx_rtr_i == e.remote_request_tag);
	assign ide_ok = !e.extension_flag_filter || (rx_ide_i == obj_ide_i);
	assign hit_o = (diff == '0) && rtr_ok && ide_ok;
endmodule

// ==== can_id_tag_mask.sv ====
`timescale 1ns/1ns
// Behaviour
// - Cleared mask bit forces that bit's comparison to match.
// - Set mask bit requires received bit to equal stored tag bit.
// - Mask used only on reception; transmit sends raw tag values.
// - Tag and mask storage has no defined value after reset.
// - Reserved bits may read back any value.
// - Extended view: identifier 28..0 spread over four tag bytes, MSB first.
// - Tag byte four bit 2 holds remote request, both views.
// - Extended view: tag byte four bit 1 holds reserved bit one.
// - Tag byte four bit 0 holds reserved bit zero, both views.
// - Standard view tag byte four implements only bits 2 and 0.
// - Standard mask bits 10..3 in byte one, 2..0 in byte two 7-5.
// - Standard view filter byte three is reserved, no filtering role.
// - Filter byte four: remote request mask bit 2, extension mask bit 0.
// - Extended filter byte one holds mask bits 28..21.
// - Standard tag: bits 10..3 byte one, 2..0 byte two top; byte three reserved.
// - Extended mask bits 20..5 in bytes two, three; 4..0 in byte four 7-3.
module can_id_tag_mask #(
	parameter int NUM_OBJ = can_id_filter_pkg::NUM_OBJ
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic [can_id_filter_pkg::ADDR_W-1:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [can_id_filter_pkg::DATA_W-1:0] sfr_wdata_i,
	input wire logic [can_id_filter_pkg::PAGE_W-1:0] obj_page_i,
	input wire logic obj_ext_fmt_i,
	input wire logic [can_id_filter_pkg::PAGE_W-1:0] rx_obj_i,
	input wire logic rx_obj_ext_fmt_i,
	input wire logic [can_id_filter_pkg::ID_W-1:0] rx_id_i,
	input wire logic rx_rtr_i,
	input wire logic rx_ide_i,
	input wire logic rx_check_i,
	input wire logic [can_id_filter_pkg::PAGE_W-1:0] tx_obj_i,
	output logic [can_id_filter_pkg::DATA_W-1:0] sfr_rdata_o,
	output logic sfr_hit_o,
	output logic rx_hit_valid_o,
	output logic rx_hit_o,
	output logic [can_id_filter_pkg::ID_W-1:0] tx_id_o,
	output logic tx_rtr_o,
	output logic tx_rb1_o,
	output logic tx_rb0_o
);
	//////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		logic [can_id_filter_pkg::DATA_W-1:0] rdata;
		logic rd_pend;
		logic [can_id_filter_pkg::ADDR_W-1:0] rd_addr;
		logic rd_ext;
		logic check_pend;
		logic check_ext;
		logic [can_id_filter_pkg::ID_W-1:0] rx_id;
		logic rx_rtr;
		logic rx_ide;
		logic hit_valid;
		logic hit;
		logic [can_id_filter_pkg::ID_W-1:0] tx_id;
		logic tx_rtr;
		logic tx_rb1;
		logic tx_rb0;
		logic wr_pend;
		logic [can_id_filter_pkg::ADDR_W-1:0] wr_addr;
		logic [can_id_filter_pkg::DATA_W-1:0] wr_data;
		logic wr_ext;
		logic [can_id_filter_pkg::PAGE_W-1:0] wr_page;
	} top_state_t;

	top_state_t s_q;
	top_state_t s_d;
	can_id_filter_pkg::obj_entry_t cur;
	can_id_filter_pkg::obj_entry_t upd;
	can_id_filter_pkg::obj_entry_t tx_e;
	logic match_hit;

	obj_store_if st();

	//////////////////////////////////////////////////////////////////////////

	// One-hot byte slot of an address on the register bus.
	// SLOT_NONE stands for every address outside the tag and filter bytes.
	typedef enum logic [8:0] {
		SLOT_NONE = 9'h001,
		SLOT_TAG_ONE = 9'h002,
		SLOT_TAG_TWO = 9'h004,
		SLOT_TAG_THREE = 9'h008,
		SLOT_TAG_FOUR = 9'h010,
		SLOT_FILT_ONE = 9'h020,
		SLOT_FILT_TWO = 9'h040,
		SLOT_FILT_THREE = 9'h080,
		SLOT_FILT_FOUR = 9'h100
	} byte_slot_t;

	function automatic byte_slot_t slot_of(input logic [can_id_filter_pkg::ADDR_W-1:0] a);
		byte_slot_t s;
		s = SLOT_NONE;
		case (a)
			can_id_filter_pkg::ADDR_TAG_BYTE_ONE: begin
				s = SLOT_TAG_ONE;
			end
			can_id_filter_pkg::ADDR_TAG_BYTE_TWO: begin
				s = SLOT_TAG_TWO;
			end
			can_id_filter_pkg::ADDR_TAG_BYTE_THREE: begin
				s = SLOT_TAG_THREE;
			end
			can_id_filter_pkg::ADDR_TAG_BYTE_FOUR: begin
				s = SLOT_TAG_FOUR;
			end
			can_id_filter_pkg::ADDR_FILTER_BYTE_ONE: begin
				s = SLOT_FILT_ONE;
			end
			can_id_filter_pkg::ADDR_FILTER_BYTE_TWO: begin
				s = SLOT_FILT_TWO;
			end
			can_id_filter_pkg::ADDR_FILTER_BYTE_THREE: begin
				s = SLOT_FILT_THREE;
			end
			can_id_filter_pkg::ADDR_FILTER_BYTE_FOUR: begin
				s = SLOT_FILT_FOUR;
			end
			default: begin
				s = SLOT_NONE;
			end
		endcase
		return s;
	endfunction

	function automatic logic is_mapped(input logic [can_id_filter_pkg::ADDR_W-1:0] a);
		byte_slot_t s;
		s = slot_of(a);
		is_mapped = (s != SLOT_NONE);
	endfunction

	// Read view of one byte; reserved positions read as zero.
	function automatic logic [7:0] view_rd(input can_id_filter_pkg::obj_entry_t e,
		input logic [7:0] a, input logic ext);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			can_id_filter_pkg::ADDR_TAG_BYTE_ONE: begin
				r = ext ? e.identifier_tag_bits[28:21] : e.identifier_tag_bits[28:21];
			end
			can_id_filter_pkg::ADDR_TAG_BYTE_TWO: begin
				r = ext ? e.identifier_tag_bits[20:13] : {e.identifier_tag_bits[20:18], 5'h00};
			end
			can_id_filter_pkg::ADDR_TAG_BYTE_THREE: begin
				r = ext ? e.identifier_tag_bits[12:5] : 8'h00;
			end
			can_id_filter_pkg::ADDR_TAG_BYTE_FOUR: begin
				r[can_id_filter_pkg::RTR_POS] = e.remote_request_tag;
				r[can_id_filter_pkg::RB0_POS] = e.reserved_zero_tag;
				if (ext) begin
					r[7:3] = e.identifier_tag_bits[4:0];
					r[can_id_filter_pkg::RB1_POS] = e.reserved_one_tag;
				end
			end
			can_id_filter_pkg::ADDR_FILTER_BYTE_ONE: begin
				r = e.identifier_mask_bits[28:21];
			end
			can_id_filter_pkg::ADDR_FILTER_BYTE_TWO: begin
				r = ext ? e.identifier_mask_bits[20:13] : {e.identifier_mask_bits[20:18], 5'h00};
			end
			can_id_filter_pkg::ADDR_FILTER_BYTE_THREE: begin
				r = ext ? e.identifier_mask_bits[12:5] : 8'h00;
			end
			can_id_filter_pkg::ADDR_FILTER_BYTE_FOUR: begin
				r[can_id_filter_pkg::RTR_POS] = e.remote_request_filter;
				r[can_id_filter_pkg::IDE_POS] = e.extension_flag_filter;
				if (ext) begin
					r[7:3] = e.identifier_mask_bits[4:0];
				end
			end
			default: begin
				r = 8'h00;
			end
		endcase
		return r;
	endfunction

	//////////////////////////////////////////////////////////////////////////

	// Writes are read-modify-write of the whole object entry; the standard
	// identifier lives in the top 11 bits so both views share storage.
	always_comb begin
		upd = cur;
		case (s_q.wr_addr)
			can_id_filter_pkg::ADDR_TAG_BYTE_ONE: begin
				upd.identifier_tag_bits[28:21] = s_q.wr_data;
			end
			can_id_filter_pkg::ADDR_TAG_BYTE_TWO: begin
				if (s_q.wr_ext) begin
					upd.identifier_tag_bits[20:13] = s_q.wr_data;
				end else begin
					upd.identifier_tag_bits[20:18] = s_q.wr_data[7:5];
				end
			end
			can_id_filter_pkg::ADDR_TAG_BYTE_THREE: begin
				if (s_q.wr_ext) begin
					upd.identifier_tag_bits[12:5] = s_q.wr_data;
				end
			end
			can_id_filter_pkg::ADDR_TAG_BYTE_FOUR: begin
				if (s_q.wr_ext) begin
					upd.identifier_tag_bits[4:0] = s_q.wr_data[7:3];
					upd.reserved_one_tag = s_q.wr_data[can_id_filter_pkg::RB1_POS];
				end
				upd.remote_request_tag = s_q.wr_data[can_id_filter_pkg::RTR_POS];
				upd.reserved_zero_tag = s_q.wr_data[can_id_filter_pkg::RB0_POS];
			end
			can_id_filter_pkg::ADDR_FILTER_BYTE_ONE: begin
				upd.identifier_mask_bits[28:21] = s_q.wr_data;
			end
			can_id_filter_pkg::ADDR_FILTER_BYTE_TWO: begin
				if (s_q.wr_ext) begin
					upd.identifier_mask_bits[20:13] = s_q.wr_data;
				end else begin
					upd.identifier_mask_bits[20:18] = s_q.wr_data[7:5];
				end
			end
			can_id_filter_pkg::ADDR_FILTER_BYTE_THREE: begin
				if (s_q.wr_ext) begin
					upd.identifier_mask_bits[12:5] = s_q.wr_data;
				end
			end
			can_id_filter_pkg::ADDR_FILTER_BYTE_FOUR: begin
				if (s_q.wr_ext) begin
					upd.identifier_mask_bits[4:0] = s_q.wr_data[7:3];
				end
				upd.remote_request_filter = s_q.wr_data[can_id_filter_pkg::RTR_POS];
				upd.extension_flag_filter = s_q.wr_data[can_id_filter_pkg::IDE_POS];
			end
			default: begin
				upd = cur;
			end
		endcase
	end

	// In the standard view the lower 18 identifier bits are forced not to
	// take part in acceptance, since that view has no way to write them.
	function automatic can_id_filter_pkg::obj_entry_t std_clip(
		input can_id_filter_pkg::obj_entry_t e, input logic ext);
		can_id_filter_pkg::obj_entry_t r;
		r = e;
		if (!ext) begin
			r.identifier_mask_bits[can_id_filter_pkg::STD_SHIFT-1:0] = '0;
		end
		return r;
	endfunction

	//////////////////////////////////////////////////////////////////////////

	// One port of the store serves the register bus (read and RMW source),
	// the other serves reception; transmit reads the live tag via port two
	// when no reception check is waiting.
	assign st.rd_idx = sfr_wr_i ? obj_page_i : (s_q.wr_pend ? s_q.wr_page : obj_page_i);
	assign st.cmp_idx = rx_check_i ? rx_obj_i : tx_obj_i;
	assign cur = st.rd_data;
	assign tx_e = st.cmp_data;
	assign st.wr_en = s_q.wr_pend;
	assign st.wr_idx = s_q.wr_page;
	assign st.wr_data = upd;

	can_obj_store #(
		.DEPTH(NUM_OBJ)
	) u_store (
		.clk_sys_i(clk_sys_i),
		.port_b(st.mem)
	);

	can_id_match u_match (
		.entry_i(std_clip(st.cmp_data, s_q.check_ext)),
		.rx_id_i(s_q.rx_id),
		.rx_rtr_i(s_q.rx_rtr),
		.rx_ide_i(s_q.rx_ide),
		.obj_ide_i(s_q.check_ext),
		.hit_o(match_hit)
	);

	//////////////////////////////////////////////////////////////////////////

	// Accesses must be spaced by one idle cycle: the merged byte reaches the
	// store one cycle after the fetch, and an access in that window sees the
	// object as it was before the write.
	always_comb begin
		s_d = s_q;
		s_d.rd_pend = sfr_rd_i && is_mapped(sfr_addr_i);
		s_d.rd_addr = sfr_addr_i;
		s_d.rd_ext = obj_ext_fmt_i;
		if (s_q.rd_pend) begin
			s_d.rdata = view_rd(cur, s_q.rd_addr, s_q.rd_ext);
		end
		// A write first fetches the object, then merges the byte next cycle.
		s_d.wr_pend = sfr_wr_i && is_mapped(sfr_addr_i);
		s_d.wr_addr = sfr_addr_i;
		s_d.wr_data = sfr_wdata_i;
		s_d.wr_ext = obj_ext_fmt_i;
		s_d.wr_page = obj_page_i;
		// The acceptance result follows two edges after the request and is
		// then held until the next request completes.
		s_d.check_pend = rx_check_i;
		s_d.check_ext = rx_obj_ext_fmt_i;
		s_d.rx_id = rx_id_i;
		s_d.rx_rtr = rx_rtr_i;
		s_d.rx_ide = rx_ide_i;
		s_d.hit_valid = s_q.check_pend;
		if (s_q.check_pend) begin
			s_d.hit = match_hit;
		end
		// Transmit values freeze while the compare port serves reception, so
		// a frame being sent never sees another object's tag for one cycle.
		if (!s_q.check_pend) begin
			s_d.tx_id = tx_e.identifier_tag_bits;
			s_d.tx_rtr = tx_e.remote_request_tag;
			s_d.tx_rb1 = tx_e.reserved_one_tag;
			s_d.tx_rb0 = tx_e.reserved_zero_tag;
		end
	end

	// The whole pipeline state is reset; the identifier storage is left as is.
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sfr_rdata_o = s_q.rdata;
	assign sfr_hit_o = s_q.rd_pend || s_q.wr_pend;
	assign rx_hit_valid_o = s_q.hit_valid;
	assign rx_hit_o = s_q.hit;
	assign tx_id_o = s_q.tx_id;
	assign tx_rtr_o = s_q.tx_rtr;
	assign tx_rb1_o = s_q.tx_rb1;
	assign tx_rb0_o = s_q.tx_rb0;
endmodule

// ==== can_id_tag_mask_properties.sv ====
`timescale 1ns/1ns
module can_id_tag_mask_checker #(
	parameter int NUM_OBJ = 15
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic obj_ext_fmt_i,
	input wire logic rx_check_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic sfr_hit_o,
	input wire logic rx_hit_valid_o,
	input wire logic rx_hit_o
);
	logic mapped;
	assign mapped = sfr_addr_i[7:2] == 6'h2F || sfr_addr_i[7:2] == 6'h31;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	sequence acc_req;
		(sfr_rd_i || sfr_wr_i) && mapped;
	endsequence
	sequence std_rd(logic [7:0] a);
		sfr_rd_i && sfr_addr_i == a && !obj_ext_fmt_i;
	endsequence
	hit_after_acc_a: assert property (acc_req |=> sfr_hit_o)
		else $error("no hit after a mapped access");
	hit_cause_a: assert property (sfr_hit_o |-> $past(mapped && (sfr_rd_i || sfr_wr_i)))
		else $error("hit without a mapped access");
	rx_latency_a: assert property (rx_check_i |-> ##2 rx_hit_valid_o)
		else $error("acceptance result late");
	rx_cause_a: assert property (rx_hit_valid_o |-> $past(rx_check_i, 2))
		else $error("acceptance result without request");
	rx_hold_a: assert property (!rx_hit_valid_o |-> $stable(rx_hit_o))
		else $error("acceptance result moved between tests");
	std_tag4_rsvd_a: assert property (std_rd(8'hBF) |-> ##2 (sfr_rdata_o & 8'hFA) == 8'h00)
		else $error("standard tag byte four reserved bits set");
	std_filt3_rsvd_a: assert property (std_rd(8'hC6) |-> ##2 sfr_rdata_o == 8'h00)
		else $error("standard filter byte three not empty");
	std_filt2_rsvd_a: assert property (std_rd(8'hC5) |-> ##2 sfr_rdata_o[4:0] == 5'h00)
		else $error("standard filter byte two reserved bits set");
	rdata_hold_a: assert property ($changed(sfr_rdata_o) |-> $past(sfr_rd_i, 2))
		else $error("read data moved without a read");
endmodule
bind can_id_tag_mask can_id_tag_mask_checker #(.NUM_OBJ(NUM_OBJ)) u_can_id_tag_mask_checker (
	.clk_sys_i(clk_sys_i),
	.resetn_i(resetn_i),
	.sfr_addr_i(sfr_addr_i),
	.sfr_wr_i(sfr_wr_i),
	.sfr_rd_i(sfr_rd_i),
	.obj_ext_fmt_i(obj_ext_fmt_i),
	.rx_check_i(rx_check_i),
	.sfr_rdata_o(sfr_rdata_o),
	.sfr_hit_o(sfr_hit_o),
	.rx_hit_valid_o(rx_hit_valid_o),
	.rx_hit_o(rx_hit_o)
);

// ==== can_msg_object_id_tag_mask_tb_top.sv ====
`timescale 1ns/1ns
module can_msg_object_id_tag_mask_tb_top;
	localparam logic [28:0] EID = {8'hA5, 8'h3C, 8'h96, 5'h1E};
	localparam logic [10:0] SID = 11'h2D7;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic ext = 1'b0;
	logic [3:0] page = 4'h0;
	logic [3:0] tx_obj = 4'h0;
	logic [3:0] rx_obj;
	logic rx_ext, rx_rtr, rx_ide, rx_chk, hit, hv, hres, trtr, trb1, trb0;
	logic [28:0] rx_id, tid;
	logic [7:0] rdata;
	logic [7:0] ad [8] = '{8'hBC, 8'hBD, 8'hBE, 8'hBF, 8'hC4, 8'hC5, 8'hC6, 8'hC7};
	logic [7:0] ev [8] = '{8'hA5, 8'h3C, 8'h96, 8'hF7, 8'hFF, 8'hFF, 8'hF0, 8'hFD};
	logic [7:0] sv [8] = '{8'h5A, 8'hE0, 8'h00, 8'h01, 8'hFF, 8'hE0, 8'h00, 8'h05};
	int mismatches = 0;
	int checks_done = 0;
	can_id_tag_mask u_can_id_tag_mask (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
		.sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata),
		.obj_page_i(page), .obj_ext_fmt_i(ext), .rx_obj_i(rx_obj), .rx_obj_ext_fmt_i(rx_ext),
		.rx_id_i(rx_id), .rx_rtr_i(rx_rtr), .rx_ide_i(rx_ide), .rx_check_i(rx_chk),
		.tx_obj_i(tx_obj), .sfr_rdata_o(rdata), .sfr_hit_o(hit), .rx_hit_valid_o(hv),
		.rx_hit_o(hres), .tx_id_o(tid), .tx_rtr_o(trtr), .tx_rb1_o(trb1), .tx_rb0_o(trb0));
	can_node_model u_can_node_model (.clk_sys_i(clk_sys_i), .rx_obj_o(rx_obj),
		.rx_ext_o(rx_ext), .rx_id_o(rx_id), .rx_rtr_o(rx_rtr), .rx_ide_o(rx_ide),
		.rx_check_o(rx_chk));
	initial begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	task automatic chk(input string what, input logic [28:0] exp, input logic [28:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic sel(input logic [3:0] p, input logic e);
		@(posedge clk_sys_i);
		#1;
		page = p;
		ext = e;
	endtask
	task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		#1;
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clk_sys_i);
		#1;
		wr = 1'b0;
		repeat (2) @(posedge clk_sys_i);
	endtask
	task automatic rd_b(input logic [7:0] a, input logic h, input logic [7:0] exp);
		@(posedge clk_sys_i);
		#1;
		addr = a;
		rd = 1'b1;
		@(posedge clk_sys_i);
		#1;
		rd = 1'b0;
		chk("access hit", h, hit);
		@(posedge clk_sys_i);
		#1;
		if (h) begin
			chk("read data", exp, rdata);
		end
	endtask
	task automatic tx_look(input logic [3:0] o);
		tx_obj = o;
		repeat (3) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic ext_regs();
		sel(4'h3, 1'b1);
		for (int i = 0; i < 8; i++) wr_b(ad[i], ev[i]);
		for (int i = 0; i < 8; i++) rd_b(ad[i], 1'b1, ev[i]);
		tx_look(4'h3);
		chk("tx id", EID, tid);
		chk("tx flags", 3'b111, {trtr, trb1, trb0});
	endtask
	task automatic std_regs();
		sel(4'h5, 1'b0);
		for (int i = 0; i < 8; i++) if (i != 2 && i != 6) wr_b(ad[i], sv[i]);
		for (int i = 0; i < 8; i++) rd_b(ad[i], 1'b1, sv[i]);
		rd_b(8'hC0, 1'b0, 8'h00);
		tx_look(4'h5);
		chk("tx std id", SID, tid[28:18]);
		chk("tx std flags", 2'b01, {trtr, trb0});
		sel(4'h3, 1'b1);
		rd_b(8'hBC, 1'b1, 8'hA5);
	endtask
	task automatic rx_case(input logic [3:0] o, input logic e, input logic [28:0] id,
		input logic rtr, input logic ide, input logic exp);
		int n;
		n = 0;
		u_can_node_model.send(o, e, id, rtr, ide);
		while (hv !== 1'b1 && n < 8) begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		chk("rx valid", 1'b1, hv);
		chk("rx hit", exp, hres);
	endtask
	task automatic rx_filter();
		rx_case(4'h3, 1'b1, EID, 1'b1, 1'b1, 1'b1);
		rx_case(4'h3, 1'b1, EID ^ 29'h20, 1'b1, 1'b1, 1'b1);
		rx_case(4'h3, 1'b1, EID ^ 29'h1, 1'b1, 1'b1, 1'b0);
		rx_case(4'h3, 1'b1, EID, 1'b0, 1'b1, 1'b0);
		rx_case(4'h3, 1'b1, EID, 1'b1, 1'b0, 1'b0);
		rx_case(4'h5, 1'b0, {SID, 18'h2AAAA}, 1'b0, 1'b0, 1'b1);
		rx_case(4'h5, 1'b0, {SID ^ 11'h1, 18'h2AAAA}, 1'b0, 1'b0, 1'b0);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_sys_i);
		#1;
		resetn_i = 1'b1;
		chk("hit after reset", 1'b0, hres);
		ext_regs();
		std_regs();
		rx_filter();
		end_of_test();
	end
	initial begin
		#100000;
		mismatches++;
		end_of_test();
	end
endmodule

// ==== can_node_model.sv ====
`timescale 1ns/1ns
module can_node_model (
	input wire logic clk_sys_i,
	output logic [3:0] rx_obj_o,
	output logic rx_ext_o,
	output logic [28:0] rx_id_o,
	output logic rx_rtr_o,
	output logic rx_ide_o,
	output logic rx_check_o
);
	initial begin
		rx_obj_o = 4'h0;
		rx_ext_o = 1'b0;
		rx_id_o = 29'h0;
		rx_rtr_o = 1'b0;
		rx_ide_o = 1'b0;
		rx_check_o = 1'b0;
	end
	// A frame is offered for one cycle; afterwards the lines carry the inverse.
	task automatic send(input logic [3:0] o, input logic e, input logic [28:0] id,
		input logic rtr, input logic ide);
		@(posedge clk_sys_i);
		#1;
		{rx_obj_o, rx_ext_o, rx_id_o, rx_rtr_o, rx_ide_o} = {o, e, id, rtr, ide};
		rx_check_o = 1'b1;
		@(posedge clk_sys_i);
		#1;
		rx_check_o = 1'b0;
		{rx_obj_o, rx_ext_o, rx_id_o, rx_rtr_o, rx_ide_o} = ~{o, e, id, rtr, ide};
	endtask
endmodule

// ==== can_obj_store.sv ====
`timescale 1ns/1ns
module can_obj_store #(
	parameter int DEPTH = can_id_filter_pkg::NUM_OBJ
) (
	input wire logic clk_sys_i,
	obj_store_if.mem port_b
);
	typedef struct packed {
		logic [can_id_filter_pkg::ENTRY_W-1:0] rd;
		logic [can_id_filter_pkg::ENTRY_W-1:0] cmp;
	} store_state_t;

	// No reset: the storage holds no defined value until written.
	logic [can_id_filter_pkg::ENTRY_W-1:0] mem_q [DEPTH];
	store_state_t s_q;
	store_state_t s_d;

	always_comb begin
		s_d.rd = mem_q[port_b.rd_idx];
		s_d.cmp = mem_q[port_b.cmp_idx];
	end

	always_ff @(posedge clk_sys_i) begin
		s_q <= s_d;
		if (port_b.wr_en) begin
			mem_q[port_b.wr_idx] <= port_b.wr_data;
		end
	end

	assign port_b.rd_data = s_q.rd;
	assign port_b.cmp_data = s_q.cmp;
endmodule

// ==== obj_store_if.sv ====
`timescale 1ns/1ns
interface obj_store_if;
	logic [can_id_filter_pkg::PAGE_W-1:0] wr_idx;
	logic wr_en;
	logic [can_id_filter_pkg::ENTRY_W-1:0] wr_data;
	logic [can_id_filter_pkg::PAGE_W-1:0] rd_idx;
	logic [can_id_filter_pkg::ENTRY_W-1:0] rd_data;
	logic [can_id_filter_pkg::PAGE_W-1:0] cmp_idx;
	logic [can_id_filter_pkg::ENTRY_W-1:0] cmp_data;

	modport ctrl (output wr_idx, output wr_en, output wr_data, output rd_idx,
		output cmp_idx, input rd_data, input cmp_data);
	modport mem (input wr_idx, input wr_en, input wr_data, input rd_idx,
		input cmp_idx, output rd_data, output cmp_data);
endinterface
